// ### verilog/exc_pkg.sv
// Shared constants and types for the exception entry unit.
package exc_pkg;

   // Exception vectors.
   localparam logic [31:0] VEC_RESET = 32'h00;
   localparam logic [31:0] VEC_UNDEF = 32'h04;
   localparam logic [31:0] VEC_SWI = 32'h08;
   localparam logic [31:0] VEC_PABT = 32'h0c;
   localparam logic [31:0] VEC_DABT = 32'h10;
   localparam logic [31:0] VEC_RSVD = 32'h14;
   localparam logic [31:0] VEC_NORMAL = 32'h18;
   localparam logic [31:0] VEC_FAST = 32'h1c;

   // Latency figures in processor cycles, and the clock period in ns.
   localparam int FAST_LAT_MAX_CYC = 50;
   localparam int FAST_LAT_NOLM_CYC = 42;
   localparam int FAST_LAT_COMPACT_CYC = 22;
   localparam int IRQ_LAT_MIN_CYC = 5;
   localparam int ENTRY_CYC = 2;
   localparam int CLK_PERIOD_NS = 100;

   // Memory map.
   localparam int REMAP_WIN_KB = 30;
   localparam logic [31:0] REMAP_WIN_BYTES = 32'(REMAP_WIN_KB * 1024);
   localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
   localparam logic [31:0] SRAM_BYTES = 32'h0000_1000;

   // Transfer sizes.
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Bus target one-hot positions.
   localparam int TGT_FLASH = 0;
   localparam int TGT_SRAM = 1;
   localparam int TGT_MMR = 2;

   // Banked register indices.
   localparam logic [3:0] IDX_HI_FIRST = 4'h8;
   localparam logic [3:0] IDX_HI_LAST = 4'hc;
   localparam logic [3:0] IDX_SP = 4'hd;
   localparam logic [3:0] IDX_LR = 4'he;

   // Reset values.
   localparam logic RESET_COMPACT = 1'b0;
   localparam logic RESET_LOW_SRAM = 1'b0;

   typedef enum logic [2:0] {MODE_USER, MODE_FAST, MODE_NORMAL, MODE_SUPER, MODE_ABORT, MODE_UNDEF} mode_e;
   typedef enum logic [2:0] {EXC_RESET, EXC_DABT, EXC_FAST, EXC_NORMAL, EXC_PABT, EXC_SWI, EXC_UNDEF} exc_e;
   typedef enum logic {ST_RUN, ST_ENTER} entry_state_e;

endpackage : exc_pkg

// ### verilog/pin_sync3.sv
// Three-stage synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Pin and filtered level
   input wire logic i_pin,
   output logic o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         level_q <= 1'b0;
      else if (s2_q == s3_q)
         level_q <= s3_q;
   end

   assign o_level = level_q;
endmodule : pin_sync3

// ### verilog/mem_window_decode.sv
// Address decoder for the remap window, SRAM, flash and register areas.
`timescale 1ns/1ps
module mem_window_decode #(
   parameter logic [31:0] FLASH_BASE = 32'h0008_0000,
   parameter logic [31:0] FLASH_BYTES = 32'h0000_7800,
   parameter logic [31:0] MMR_BASE = 32'hffff_0000
) (
   // Request
   input wire logic [31:0] i_addr,
   input wire logic [1:0] i_size,
   input wire logic [31:0] i_wdata,
   input wire logic i_low_sram,
   // Decode result
   output logic [2:0] o_target,
   output logic o_abort,
   output logic [31:0] o_phys_addr,
   output logic [3:0] o_lanes,
   output logic [31:0] o_wdata
);
   localparam logic [31:0] SRAM_END = exc_pkg::SRAM_BASE + exc_pkg::SRAM_BYTES;

   if (FLASH_BYTES == 32'h0 || MMR_BASE <= SRAM_END)
   begin : g_bad_map
      $error("mem_window_decode: flash size or register base unusable");
   end

   logic [31:0] off;

   always_comb
   begin
      o_target = 3'h0;
      o_phys_addr = i_addr;
      off = i_addr;
      // Low window shows flash or SRAM; a hole beyond the mapped memory aborts.
      if (i_addr < exc_pkg::REMAP_WIN_BYTES) //RL15
      begin
         if (i_low_sram)
         begin
            if (off < exc_pkg::SRAM_BYTES)
            begin
               o_target[exc_pkg::TGT_SRAM] = 1'b1;
               o_phys_addr = exc_pkg::SRAM_BASE + off;
            end
         end
         else if (off < FLASH_BYTES)
         begin
            o_target[exc_pkg::TGT_FLASH] = 1'b1;
            o_phys_addr = FLASH_BASE + off;
         end
      end
      else if (i_addr >= exc_pkg::SRAM_BASE && i_addr < SRAM_END)
         o_target[exc_pkg::TGT_SRAM] = 1'b1;
      else if (i_addr >= FLASH_BASE && i_addr - FLASH_BASE < FLASH_BYTES)
         o_target[exc_pkg::TGT_FLASH] = 1'b1;
      else if (i_addr >= MMR_BASE)
         o_target[exc_pkg::TGT_MMR] = 1'b1;
      o_abort = (o_target == 3'h0); //RL14
   end

   // Least significant byte sits in the lowest lane.
   always_comb
   begin
      case (i_size) //RL16 RL20
         exc_pkg::SIZE_BYTE:
         begin
            o_lanes = 4'h1 << i_addr[1:0];
            o_wdata = {4{i_wdata[7:0]}};
         end
         exc_pkg::SIZE_HALF:
         begin
            o_lanes = i_addr[1] ? 4'hc : 4'h3;
            o_wdata = {2{i_wdata[15:0]}};
         end
         default:
         begin
            o_lanes = 4'hf;
            o_wdata = i_wdata;
         end
      endcase
   end
endmodule : mem_window_decode

// ### verilog/core_exception_entry.sv
// Exception entry, register banking, memory view and multiplier of the processor core.
`timescale 1ns/1ps
// Operation
// [RL1] Each exception fetches its fixed vector
// [RL2] Fixed priority among simultaneous exceptions
// [RL3] Vector word 0x14 is never used
// [RL4] Software interrupt and undefined are exclusive
// [RL5] Fast interrupt wins over normal interrupt
// [RL6] Controller gives eight levels per type
// [RL7] Each mode banks stack and link registers
// [RL8] Fast mode also banks registers eight-twelve
// [RL9] Link holds return or faulting address
// [RL10] Handler starts in 32-bit instruction state
// [RL11] Fast interrupt latency at most 50 cycles
// [RL12] Latency 42 without multi-load, 22 compact
// [RL13] Minimum interrupt latency is five cycles
// [RL14] Unmapped access raises data abort
// [RL15] Lowest 30 kB window shows flash/SRAM
// [RL16] Multi-byte values are little-endian
// [RL17] Breakpoint or watchpoint halts into debug
// [RL18] 32x32 multiply and accumulate, 64-bit result
// [RL19] 32-bit or 16-bit instructions, one bus
// [RL20] Bus transfers of 8, 16, 32 bits
// [RL21] Any reset maps flash back low
// [RL22] Entry saves status, disables normal interrupts
module core_exception_entry (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Interrupt request pins
   input wire logic i_fast_req,
   input wire logic i_normal_req,
   // Instruction status
   input wire logic i_insn_boundary,
   input wire logic i_insn_undef,
   input wire logic i_insn_swi,
   input wire logic i_prefetch_abort,
   input wire logic [31:0] i_insn_addr,
   input wire logic [31:0] i_status,
   input wire logic i_exc_return,
   input wire logic i_state_wr,
   input wire logic i_state_compact,
   input wire logic i_soft_reset,
   // Branch with link
   input wire logic i_bl_pulse,
   input wire logic [31:0] i_bl_ret,
   // Banked register port
   input wire logic i_rf_we,
   input wire logic [3:0] i_rf_idx,
   input wire logic [31:0] i_rf_wdata,
   input wire logic [3:0] i_rf_ridx,
   // Debug
   input wire logic i_bkpt_match,
   input wire logic i_wpt_match,
   input wire logic i_debug_resume,
   // Shared bus request
   input wire logic i_bus_req,
   input wire logic i_bus_we,
   input wire logic [31:0] i_bus_addr,
   input wire logic [1:0] i_bus_size,
   input wire logic [31:0] i_bus_wdata,
   input wire logic i_remap_wr,
   input wire logic i_remap_sram,
   // Multiplier
   input wire logic i_mul_start,
   input wire logic i_mul_acc,
   input wire logic i_mul_signed,
   input wire logic [31:0] i_mul_a,
   input wire logic [31:0] i_mul_b,
   input wire logic [63:0] i_mul_addend,
   // Exception entry
   output logic o_vec_valid,
   output logic [31:0] o_vec_addr,
   output logic [2:0] o_mode,
   output logic o_compact,
   output logic o_irq_disable,
   output logic o_fast_disable,
   output logic [31:0] o_saved_status,
   output logic o_debug_halt,
   output logic [31:0] o_rf_rdata,
   // Shared bus answer
   output logic o_bus_valid,
   output logic o_bus_we,
   output logic o_bus_abort,
   output logic [31:0] o_bus_addr,
   output logic [3:0] o_bus_lanes,
   output logic [31:0] o_bus_wdata,
   output logic [2:0] o_bus_target,
   output logic o_low_is_sram,
   // Multiplier result
   output logic o_mul_done,
   output logic [63:0] o_mul_result
);
   exc_pkg::entry_state_e st_q;
   exc_pkg::exc_e exc_q;
   exc_pkg::exc_e sel;
   exc_pkg::mode_e mode_q;
   logic take;
   logic fast_lvl;
   logic normal_lvl;
   logic vec_valid_q, compact_q, irq_dis_q, fast_dis_q, halt_q, dabt_pend_q, low_sram_q;
   logic [31:0] vec_addr_q, fault_pc_q, rdata_q;
   logic [31:0] sp_bank [6];
   logic [31:0] lr_bank [6];
   logic [31:0] spsr_bank [6];
   logic [31:0] hi_user [5];
   logic [31:0] hi_fast [5];
   logic [2:0] dec_target;
   logic dec_abort;
   logic [31:0] dec_addr, dec_wdata;
   logic [3:0] dec_lanes;
   logic bus_valid_q, bus_we_q, bus_abort_q, mul_done_q;
   logic [31:0] bus_addr_q, bus_wdata_q;
   logic [3:0] bus_lanes_q;
   logic [2:0] bus_target_q;
   logic [63:0] mul_q;
   logic [63:0] prod;

   // Requests from the interrupt controller arrive from outside this clock.
   pin_sync3 u_fast_sync (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_pin(i_fast_req), .o_level(fast_lvl));
   pin_sync3 u_normal_sync (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_pin(i_normal_req), .o_level(normal_lvl));

   mem_window_decode u_dec (
      .i_addr(i_bus_addr), .i_size(i_bus_size), .i_wdata(i_bus_wdata), .i_low_sram(low_sram_q),
      .o_target(dec_target), .o_abort(dec_abort), .o_phys_addr(dec_addr), .o_lanes(dec_lanes),
      .o_wdata(dec_wdata)
   );

   function automatic logic [31:0] vec_of(exc_pkg::exc_e e);
      case (e) //RL1 RL3
         exc_pkg::EXC_DABT: vec_of = exc_pkg::VEC_DABT;
         exc_pkg::EXC_FAST: vec_of = exc_pkg::VEC_FAST;
         exc_pkg::EXC_NORMAL: vec_of = exc_pkg::VEC_NORMAL;
         exc_pkg::EXC_PABT: vec_of = exc_pkg::VEC_PABT;
         exc_pkg::EXC_SWI: vec_of = exc_pkg::VEC_SWI;
         exc_pkg::EXC_UNDEF: vec_of = exc_pkg::VEC_UNDEF;
         default: vec_of = exc_pkg::VEC_RESET;
      endcase
   endfunction : vec_of

   function automatic exc_pkg::mode_e mode_of(exc_pkg::exc_e e);
      case (e)
         exc_pkg::EXC_DABT, exc_pkg::EXC_PABT: mode_of = exc_pkg::MODE_ABORT;
         exc_pkg::EXC_FAST: mode_of = exc_pkg::MODE_FAST;
         exc_pkg::EXC_NORMAL: mode_of = exc_pkg::MODE_NORMAL;
         exc_pkg::EXC_UNDEF: mode_of = exc_pkg::MODE_UNDEF;
         default: mode_of = exc_pkg::MODE_SUPER;
      endcase
   endfunction : mode_of

   // Pick the highest pending exception at an instruction boundary, or a soft reset in any cycle.
   always_comb
   begin
      take = 1'b1;
      sel = exc_pkg::EXC_RESET;
      if (i_soft_reset)
         sel = exc_pkg::EXC_RESET; //RL2
      else if (st_q != exc_pkg::ST_RUN || halt_q || !i_insn_boundary)
         take = 1'b0;
      else if (dabt_pend_q)
         sel = exc_pkg::EXC_DABT;
      else if (fast_lvl && !fast_dis_q)
         sel = exc_pkg::EXC_FAST; //RL5 RL11 RL12
      else if (normal_lvl && !irq_dis_q)
         sel = exc_pkg::EXC_NORMAL;
      else if (i_prefetch_abort)
         sel = exc_pkg::EXC_PABT;
      else if (i_insn_undef)
         sel = exc_pkg::EXC_UNDEF; //RL4
      else if (i_insn_swi)
         sel = exc_pkg::EXC_SWI;
      else
         take = 1'b0;
   end

   // Entry takes a decision cycle and an entry cycle after the synchroniser.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_q <= exc_pkg::ST_ENTER;
         exc_q <= exc_pkg::EXC_RESET;
         fault_pc_q <= 32'h0;
      end
      else if (take)
      begin
         st_q <= exc_pkg::ST_ENTER; //RL13
         exc_q <= sel;
         fault_pc_q <= i_insn_addr;
      end
      else
         st_q <= exc_pkg::ST_RUN;
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         vec_valid_q <= 1'b0;
         vec_addr_q <= exc_pkg::VEC_RESET;
         mode_q <= exc_pkg::MODE_SUPER;
         compact_q <= exc_pkg::RESET_COMPACT;
         irq_dis_q <= 1'b1;
         fast_dis_q <= 1'b1;
      end
      else
      begin
         vec_valid_q <= (st_q == exc_pkg::ST_ENTER);
         if (st_q == exc_pkg::ST_ENTER)
         begin
            vec_addr_q <= vec_of(exc_q); //RL1
            mode_q <= mode_of(exc_q); //RL7
            compact_q <= 1'b0; //RL10 RL19
            irq_dis_q <= 1'b1; //RL22
            if (exc_q == exc_pkg::EXC_FAST || exc_q == exc_pkg::EXC_RESET)
               fast_dis_q <= 1'b1;
         end
         else if (i_exc_return)
         begin
            mode_q <= exc_pkg::MODE_USER;
            irq_dis_q <= 1'b0;
            fast_dis_q <= 1'b0;
         end
         else if (i_state_wr)
            compact_q <= i_state_compact;
      end
   end

   // Banked stack, link, saved status and fast-mode high registers.
   always_ff @(posedge i_ref_clk)
   begin
      if (st_q == exc_pkg::ST_ENTER)
      begin
         spsr_bank[mode_of(exc_q)] <= i_status; //RL22
         lr_bank[mode_of(exc_q)] <= fault_pc_q; //RL9
      end
      else if (i_bl_pulse)
         lr_bank[mode_q] <= i_bl_ret; //RL9
      else if (i_rf_we && i_rf_idx == exc_pkg::IDX_LR)
         lr_bank[mode_q] <= i_rf_wdata; //RL7
      if (i_rf_we && i_rf_idx == exc_pkg::IDX_SP)
         sp_bank[mode_q] <= i_rf_wdata; //RL7
      if (i_rf_we && i_rf_idx >= exc_pkg::IDX_HI_FIRST && i_rf_idx <= exc_pkg::IDX_HI_LAST)
      begin
         if (mode_q == exc_pkg::MODE_FAST)
            hi_fast[3'(i_rf_idx - exc_pkg::IDX_HI_FIRST)] <= i_rf_wdata; //RL8
         else
            hi_user[3'(i_rf_idx - exc_pkg::IDX_HI_FIRST)] <= i_rf_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rdata_q <= 32'h0;
      else if (i_rf_ridx == exc_pkg::IDX_SP)
         rdata_q <= sp_bank[mode_q];
      else if (i_rf_ridx == exc_pkg::IDX_LR)
         rdata_q <= lr_bank[mode_q];
      else if (i_rf_ridx >= exc_pkg::IDX_HI_FIRST && i_rf_ridx <= exc_pkg::IDX_HI_LAST)
         rdata_q <= (mode_q == exc_pkg::MODE_FAST) ? hi_fast[3'(i_rf_ridx - exc_pkg::IDX_HI_FIRST)] :
            hi_user[3'(i_rf_ridx - exc_pkg::IDX_HI_FIRST)]; //RL8
      else
         rdata_q <= 32'h0;
   end

   // Debug halt: a new match wins over a resume in the same cycle.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         halt_q <= 1'b0;
      else if (i_bkpt_match || i_wpt_match)
         halt_q <= 1'b1; //RL17
      else if (i_debug_resume)
         halt_q <= 1'b0;
   end

   // Remap state returns to flash on any reset.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         low_sram_q <= exc_pkg::RESET_LOW_SRAM;
      else if (i_soft_reset)
         low_sram_q <= exc_pkg::RESET_LOW_SRAM; //RL21
      else if (i_remap_wr)
         low_sram_q <= i_remap_sram;
   end

   // Bus access: unmapped addresses abort and stay pending until entry.
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         bus_valid_q <= 1'b0;
         bus_we_q <= 1'b0;
         bus_abort_q <= 1'b0;
         bus_addr_q <= 32'h0;
         bus_lanes_q <= 4'h0;
         bus_wdata_q <= 32'h0;
         bus_target_q <= 3'h0;
         dabt_pend_q <= 1'b0;
      end
      else
      begin
         bus_valid_q <= i_bus_req && !dec_abort;
         bus_abort_q <= i_bus_req && dec_abort; //RL14
         if (i_bus_req)
         begin
            bus_we_q <= i_bus_we;
            bus_addr_q <= dec_addr;
            bus_lanes_q <= dec_abort ? 4'h0 : dec_lanes; //RL16 RL20
            bus_wdata_q <= dec_wdata;
            bus_target_q <= dec_target;
         end
         if (i_bus_req && dec_abort)
            dabt_pend_q <= 1'b1; //RL14
         else if (take && sel == exc_pkg::EXC_DABT)
            dabt_pend_q <= 1'b0;
      end
   end

   // Multiply and multiply-accumulate with a full 64-bit result.
   always_comb
   begin
      if (i_mul_signed)
         prod = 64'($signed({{32{i_mul_a[31]}}, i_mul_a}) * $signed({{32{i_mul_b[31]}}, i_mul_b}));
      else
         prod = {32'h0, i_mul_a} * {32'h0, i_mul_b};
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mul_q <= 64'h0;
         mul_done_q <= 1'b0;
      end
      else
      begin
         mul_done_q <= i_mul_start;
         if (i_mul_start)
            mul_q <= i_mul_acc ? prod + i_mul_addend : prod; //RL18
      end
   end

   assign o_vec_valid = vec_valid_q;
   assign o_vec_addr = vec_addr_q;
   assign o_mode = mode_q;
   assign o_compact = compact_q;
   assign o_irq_disable = irq_dis_q;
   assign o_fast_disable = fast_dis_q;
   assign o_saved_status = spsr_bank[mode_q];
   assign o_debug_halt = halt_q;
   assign o_rf_rdata = rdata_q;
   assign o_bus_valid = bus_valid_q;
   assign o_bus_we = bus_we_q;
   assign o_bus_abort = bus_abort_q;
   assign o_bus_addr = bus_addr_q;
   assign o_bus_lanes = bus_lanes_q;
   assign o_bus_wdata = bus_wdata_q;
   assign o_bus_target = bus_target_q;
   assign o_low_is_sram = low_sram_q;
   assign o_mul_done = mul_done_q;
   assign o_mul_result = mul_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   vec_not_reserved_a: assert property (o_vec_valid |-> o_vec_addr != exc_pkg::VEC_RSVD) //RL3
      else $error("reserved vector used");
   vec_matches_mode_a: assert property (o_vec_valid && o_vec_addr == exc_pkg::VEC_FAST |->
      o_mode == exc_pkg::MODE_FAST && o_fast_disable) //RL1
      else $error("fast vector without fast mode");
   entry_compact_a: assert property (o_vec_valid |-> !o_compact && o_irq_disable) //RL10
      else $error("handler not in 32-bit state or interrupts open");
   fast_first_a: assert property (take && fast_lvl && !fast_dis_q && !dabt_pend_q && !i_soft_reset |->
      ##2 o_vec_valid && o_vec_addr == exc_pkg::VEC_FAST) //RL5
      else $error("fast interrupt not entered in two cycles");
   dabt_first_a: assert property (take && dabt_pend_q && !i_soft_reset |=> exc_q == exc_pkg::EXC_DABT) //RL2
      else $error("data abort lost priority");
   undef_swi_excl_a: assert property (take && i_insn_undef && i_insn_swi |-> sel != exc_pkg::EXC_SWI) //RL4
      else $error("both software interrupt and undefined raised");
   unmapped_abort_a: assert property (i_bus_req && dec_abort |=> o_bus_abort && !o_bus_valid ##0 dabt_pend_q) //RL14
      else $error("unmapped access completed");
   halt_on_match_a: assert property (i_bkpt_match || i_wpt_match |=> //RL17
      o_debug_halt ##0 (!take || i_soft_reset))
      else $error("no halt after breakpoint");
   remap_reset_a: assert property (i_soft_reset |=> !o_low_is_sram ##1 o_vec_valid) //RL21
      else $error("reset did not restore flash low");
   mac_result_a: assert property (i_mul_start && i_mul_acc |=>
      o_mul_done && o_mul_result == $past(prod) + $past(i_mul_addend)) //RL18
      else $error("accumulate result wrong");
   link_saved_a: assert property (st_q == exc_pkg::ST_ENTER |=> lr_bank[o_mode] == $past(fault_pc_q)) //RL9
      else $error("link not loaded on entry");

   fast_entry_c: cover property (o_vec_valid && o_vec_addr == exc_pkg::VEC_FAST);
   normal_entry_c: cover property (o_vec_valid && o_vec_addr == exc_pkg::VEC_NORMAL);
   dabt_entry_c: cover property (o_bus_abort ##[1:20] o_vec_valid && o_vec_addr == exc_pkg::VEC_DABT);
   debug_halt_c: cover property (o_debug_halt ##1 !o_debug_halt);
endmodule : core_exception_entry

// ### verification/irq_ctrl_model.sv
// Interrupt controller model with eight priority levels per request type.
`timescale 1ns/1ps
module irq_ctrl_model (
   // Sources, source n at level n, and the lowest level let through
   input wire logic [7:0] i_fast_src,
   input wire logic [7:0] i_normal_src,
   input wire logic [2:0] i_fast_floor,
   input wire logic [2:0] i_normal_floor,
   // Requests to the core
   output logic o_fast_req,
   output logic o_normal_req
);
   always_comb
   begin
      o_fast_req = 1'b0;
      o_normal_req = 1'b0;
      for (int n = 0; n < 8; n++)
      begin
         if (i_fast_src[n] && n >= i_fast_floor) o_fast_req = 1'b1;
         if (i_normal_src[n] && n >= i_normal_floor) o_normal_req = 1'b1;
      end
   end
endmodule : irq_ctrl_model

// ### verification/core_exception_entry_bench.sv
// Self-checking bench for the exception entry unit.
`timescale 1ns/1ps
module core_exception_entry_bench;
   logic i_ref_clk = '0, i_resetn = '0, i_insn_boundary = '1, i_insn_undef = '0, i_insn_swi = '0;
   logic i_prefetch_abort = '0, i_exc_return = '0, i_state_wr = '0, i_state_compact = '0, i_soft_reset = '0;
   logic i_bl_pulse = '0, i_rf_we = '0, i_bkpt_match = '0, i_wpt_match = '0, i_debug_resume = '0;
   logic i_bus_req = '0, i_bus_we = '0, i_remap_wr = '0, i_remap_sram = '0, i_mul_start = '0, i_mul_acc = '0;
   logic i_mul_signed = '0, i_fast_req, i_normal_req, o_vec_valid, o_compact, o_irq_disable, o_fast_disable;
   logic o_debug_halt, o_bus_valid, o_bus_we, o_bus_abort, o_low_is_sram, o_mul_done;
   logic [1:0] i_bus_size = '0;
   logic [2:0] ffloor = '0, o_mode, o_bus_target;
   logic [3:0] i_rf_idx = '0, i_rf_ridx = '0, o_bus_lanes;
   logic [7:0] fsrc = '0, nsrc = '0;
   logic [31:0] i_insn_addr = '0, i_status = '0, i_bl_ret = '0, i_rf_wdata = '0, i_bus_addr = '0;
   logic [31:0] i_bus_wdata = '0, i_mul_a = '0, i_mul_b = '0, rv, a, seed = 32'h5770;
   logic [31:0] o_vec_addr, o_saved_status, o_rf_rdata, o_bus_addr, o_bus_wdata;
   logic [63:0] i_mul_addend = '0, o_mul_result;
   logic [34:0] vq[$];
   logic [72:0] bq[$];
   logic [63:0] mq[$];
   int failures = 0, checks = 0, n;
   irq_ctrl_model irq (.i_fast_src(fsrc), .i_normal_src(nsrc), .i_fast_floor(ffloor), .i_normal_floor(3'h0),
      .o_fast_req(i_fast_req), .o_normal_req(i_normal_req));
   core_exception_entry dut (.*);
   always #50 i_ref_clk = ~i_ref_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic step();
      @(posedge i_ref_clk);
      #1;
   endtask : step
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // Counts edges from the first one that samples the request until the vector fetch shows.
   task automatic waitv();
      n = 0;
      while (o_vec_valid !== 1'b1 && n < 60)
      begin
         step();
         n++;
      end
      if (n == 60)
      begin
         chk(0, 1);
         complete_run();
      end
   endtask : waitv
   task automatic ret();
      i_exc_return = 1;
      step();
      i_exc_return = 0;
   endtask : ret
   task automatic sx(input logic [2:0] k, input logic [2:0] m, input logic [31:0] v);
      vq.push_back({m, v});
      {i_insn_undef, i_insn_swi, i_prefetch_abort} = k;
      step();
      {i_insn_undef, i_insn_swi, i_prefetch_abort} = 3'h0;
      waitv();
      ret();
   endtask : sx
   task automatic wr(input logic [3:0] x, input logic [31:0] d);
      i_rf_we = 1;
      i_rf_idx = x;
      i_rf_wdata = d;
      step();
   endtask : wr
   task automatic rd(input logic [3:0] x, input logic [31:0] e);
      i_rf_ridx = x;
      step();
      chk(o_rf_rdata, e);
   endtask : rd
   task automatic bus(input logic [31:0] ad, input logic [31:0] p, input logic [1:0] s, input logic [39:0] e);
      bq.push_back({rv[0], p, e});
      i_bus_req = 1;
      i_bus_we = rv[0];
      i_bus_addr = ad;
      i_bus_size = s;
      i_bus_wdata = rv;
      step();
   endtask : bus
   task automatic mul(input logic acc, input logic sg);
      logic signed [63:0] sa, sb;
      i_mul_a = rnd();
      i_mul_b = rnd();
      i_mul_addend = {rnd(), rnd()};
      i_mul_acc = acc;
      i_mul_signed = sg;
      sa = {{32{sg & i_mul_a[31]}}, i_mul_a};
      sb = {{32{sg & i_mul_b[31]}}, i_mul_b};
      mq.push_back(sa * sb + (acc ? i_mul_addend : 64'h0));
      i_mul_start = 1;
      step();
   endtask : mul
   always @(negedge i_ref_clk)
   begin
      if (o_vec_valid === 1'b1) chk({o_mode, o_vec_addr}, vq.size() ? vq.pop_front() : '1);
      if (o_bus_valid === 1'b1 || o_bus_abort === 1'b1)
         chk({o_bus_we, o_bus_addr, o_bus_abort, o_bus_lanes,
            o_bus_abort ? 35'h0 : {o_bus_target, o_bus_wdata}}, bq.size() ? bq.pop_front() : 'x);
      if (o_mul_done === 1'b1) chk(o_mul_result, mq.size() ? mq.pop_front() : 'x);
   end
   initial
   begin
      vq.push_back({exc_pkg::MODE_SUPER, exc_pkg::VEC_RESET});
      repeat (8) step();
      i_resetn = 1;
      waitv();
      chk(o_low_is_sram, 0);
      ret();
      wr(exc_pkg::IDX_SP, 32'ha0);
      wr(exc_pkg::IDX_HI_FIRST, 32'ha8);
      i_rf_we = 0;
      i_state_wr = 1;
      i_state_compact = 1;
      step();
      i_state_wr = 0;
      i_status = rnd();
      i_insn_addr = rnd();
      ffloor = 3'h7;
      fsrc = 8'h7f;
      repeat (8) step();
      vq.push_back({exc_pkg::MODE_FAST, exc_pkg::VEC_FAST});
      fsrc = 8'h80;
      waitv();
      chk(64'(n - 1), 5);
      chk({o_compact, o_irq_disable, o_fast_disable, o_saved_status}, {3'h3, i_status});
      rd(exc_pkg::IDX_LR, i_insn_addr);
      wr(exc_pkg::IDX_SP, 32'hb0);
      wr(exc_pkg::IDX_HI_FIRST, 32'hb8);
      i_rf_we = 0;
      rd(exc_pkg::IDX_SP, 32'hb0);
      rd(exc_pkg::IDX_HI_FIRST, 32'hb8);
      fsrc = 0;
      repeat (4) step();
      ret();
      rd(exc_pkg::IDX_SP, 32'ha0);
      rd(exc_pkg::IDX_HI_FIRST, 32'ha8);
      i_insn_boundary = 0;
      fsrc = 8'h80;
      nsrc = 8'h01;
      repeat (6) step();
      vq.push_back({exc_pkg::MODE_FAST, exc_pkg::VEC_FAST});
      i_insn_boundary = 1;
      i_prefetch_abort = 1;
      step();
      i_prefetch_abort = 0;
      waitv();
      fsrc = 0;
      repeat (4) step();
      vq.push_back({exc_pkg::MODE_NORMAL, exc_pkg::VEC_NORMAL});
      ret();
      waitv();
      nsrc = 0;
      repeat (4) step();
      ret();
      sx(3'h4, exc_pkg::MODE_UNDEF, exc_pkg::VEC_UNDEF);
      sx(3'h2, exc_pkg::MODE_SUPER, exc_pkg::VEC_SWI);
      sx(3'h1, exc_pkg::MODE_ABORT, exc_pkg::VEC_PABT);
      sx(3'h6, exc_pkg::MODE_UNDEF, exc_pkg::VEC_UNDEF);
      a = exc_pkg::SRAM_BASE + (rnd() & 32'hffc);
      rv = rnd();
      bus(32'h0, 32'h0008_0000, exc_pkg::SIZE_WORD, {8'h79, rv});
      rv = rnd();
      bus(a, a, exc_pkg::SIZE_WORD, {8'h7a, rv});
      rv = rnd();
      bus(a | 32'h3, a | 32'h3, exc_pkg::SIZE_BYTE, {8'h42, {4{rv[7:0]}}});
      rv = rnd();
      bus(a | 32'h2, a | 32'h2, exc_pkg::SIZE_HALF, {8'h62, {2{rv[15:0]}}});
      vq.push_back({exc_pkg::MODE_ABORT, exc_pkg::VEC_DABT});
      bus(32'h1000_0000, 32'h1000_0000, exc_pkg::SIZE_WORD, {1'b1, 39'h0});
      i_bus_req = 0;
      waitv();
      ret();
      i_remap_wr = 1;
      i_remap_sram = 1;
      step();
      i_remap_wr = 0;
      chk(o_low_is_sram, 1);
      rv = rnd();
      bus(32'h100, exc_pkg::SRAM_BASE + 32'h100, exc_pkg::SIZE_WORD, {8'h7a, rv});
      i_bus_req = 0;
      vq.push_back({exc_pkg::MODE_SUPER, exc_pkg::VEC_RESET});
      i_soft_reset = 1;
      step();
      i_soft_reset = 0;
      waitv();
      chk(o_low_is_sram, 0);
      ret();
      mul(0, 0);
      mul(1, 0);
      mul(1, 1);
      i_mul_start = 0;
      for (int k = 0; k < 2; k++)
      begin
         {i_wpt_match, i_bkpt_match} = k ? 2'h2 : 2'h1;
         step();
         {i_wpt_match, i_bkpt_match} = 2'h0;
         fsrc = 8'h80;
         repeat (8) step();
         chk(o_debug_halt, 1);
         fsrc = 0;
         repeat (4) step();
         i_debug_resume = 1;
         step();
         i_debug_resume = 0;
         step();
         chk(o_debug_halt, 0);
      end
      repeat (4) step();
      chk(vq.size() + bq.size() + mq.size(), 0);
      complete_run();
   end
endmodule : core_exception_entry_bench
